// File: inc/acs_params.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * conversion sequencer. Assumes a 20 MHz main clock and a byte-addressed
 * register window of 32-bit words.
 */
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Register byte offsets
`define ACS_OFF_CTRL_A 5'h00
`define ACS_OFF_CTRL_F 5'h04
`define ACS_OFF_TIMING 5'h08
`define ACS_OFF_CMD 5'h0C
`define ACS_OFF_STATUS 5'h10
`define ACS_OFF_RESULT 5'h14

// Field positions
`define ACS_A_ENABLE 0
`define ACS_A_KEEP 1
`define ACS_F_COUNT_MSB 3
`define ACS_F_COUNT_LSB 0
`define ACS_F_RESTART 4
`define ACS_T_SD_MSB 7
`define ACS_T_SD_LSB 0
`define ACS_T_PRE_MSB 15
`define ACS_T_PRE_LSB 8
`define ACS_T_MODE_MSB 17
`define ACS_T_MODE_LSB 16
`define ACS_C_START 0
`define ACS_S_BUSY 0
`define ACS_S_READY 1
`define ACS_S_ANALOG 2

// Reset values
`define ACS_RST_CTRL_A 32'h0000_0000
`define ACS_RST_CTRL_F 32'h0000_0000
`define ACS_RST_TIMING 32'h0000_0114

// Widths and limits
`define ACS_SAMPLE_W 12
`define ACS_ACC_W 22
`define ACS_MAX_COUNT_LOG 4'hA

// Timing
`define ACS_CLK_PERIOD_NS 50
`define ACS_INIT_TIME_NS 10000
`define ACS_INIT_CYCLES ((`ACS_INIT_TIME_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS)
`define ACS_CONV8_CYC 16'h0009
`define ACS_CONV12_CYC 16'h000D

`endif

// File: inc/acs_pkg.sv
/*
 * Types of the conversion sequencer: conversion modes and sequencer states.
 * Assumes the constants of acs_params.svh are included by the user.
 */
package acs_pkg;

	typedef enum logic [1:0] {
		ACS_MODE_SINGLE12 = 2'b00,
		ACS_MODE_SINGLE8 = 2'b01,
		ACS_MODE_SERIES = 2'b10,
		ACS_MODE_BURST = 2'b11
	} acs_mode_t;

	typedef enum logic [2:0] {
		ACS_ST_IDLE = 3'b000,
		ACS_ST_INIT = 3'b001,
		ACS_ST_START = 3'b010,
		ACS_ST_SAMPLE = 3'b011,
		ACS_ST_CONVERT = 3'b100,
		ACS_ST_GAP = 3'b101,
		ACS_ST_LATCH = 3'b110,
		ACS_ST_ACCUM = 3'b111
	} acs_state_t;

endpackage

// File: design/acs_sequencer.sv
/*
 * Conversion sequencer: converter half-clock timebase, init / sample /
 * convert / result sequencing, accumulation and an Avalon-MM register slave.
 * Assumes the analog stage presents a settled sample on ADC_DATA_I by the
 * end of the conversion phase; that bus is asynchronous and synchronised here.
 */
`timescale 1ns/100ps
`include "acs_params.svh"

////////////////////////////////////////////////////////////////////////////////
module acs_sequencer import acs_pkg::*; #(
	parameter int INIT_CYCLES = `ACS_INIT_CYCLES
) (
	// Clock, reset, enable
	input wire logic CLK_I,
	input wire logic RSTN_I,
	input wire logic CE_I,
	// Avalon-MM slave
	input wire logic [4:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	output logic [31:0] AVS_READDATA_O,
	output logic AVS_WAITREQUEST_O,
	// Analog stage
	input wire logic [11:0] ADC_DATA_I,
	output logic ANALOG_ON_O,
	output logic SAMPLE_O,
	output logic CONVERT_O,
	output logic RES8_O
);

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_s1_reg;
	logic rst_s2_reg;
	logic rstn;

	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rstn = rst_s2_reg;

	////////////////////////////////////////////////////////////////////////
	// Bus handshake and decode
	logic ack_reg;
	logic req;
	logic acc_wr;
	logic acc_rd;
	logic [31:0] ctrl_a_reg;
	logic [31:0] ctrl_f_reg;
	logic [31:0] timing_reg;
	logic [31:0] rdata_reg;
	logic [31:0] status_word;
	logic [31:0] result_word;
	logic [31:0] rd_value;
	logic hit_a;
	logic hit_f;
	logic hit_t;
	logic hit_c;
	logic hit_s;
	logic hit_r;

	assign req = AVS_READ_I | AVS_WRITE_I;
	assign AVS_WAITREQUEST_O = req & ~ack_reg;
	assign acc_wr = AVS_WRITE_I & ack_reg;
	assign acc_rd = AVS_READ_I & ack_reg;
	assign hit_a = AVS_ADDRESS_I == `ACS_OFF_CTRL_A;
	assign hit_f = AVS_ADDRESS_I == `ACS_OFF_CTRL_F;
	assign hit_t = AVS_ADDRESS_I == `ACS_OFF_TIMING;
	assign hit_c = AVS_ADDRESS_I == `ACS_OFF_CMD;
	assign hit_s = AVS_ADDRESS_I == `ACS_OFF_STATUS;
	assign hit_r = AVS_ADDRESS_I == `ACS_OFF_RESULT;
	assign rd_value = hit_a ? ctrl_a_reg :
		hit_f ? ctrl_f_reg :
		hit_t ? timing_reg :
		hit_s ? status_word :
		hit_r ? result_word : 32'h0000_0000;
	assign AVS_READDATA_O = rdata_reg;

	always_ff @(posedge CLK_I or negedge rstn) begin
		if (!rstn) begin
			ack_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else if (CE_I) begin
			ack_reg <= req & ~ack_reg;
			if (AVS_READ_I && !ack_reg) begin
				rdata_reg <= rd_value;
			end
		end
	end

	always_ff @(posedge CLK_I or negedge rstn) begin
		if (!rstn) begin
			ctrl_a_reg <= `ACS_RST_CTRL_A;
			ctrl_f_reg <= `ACS_RST_CTRL_F;
			timing_reg <= `ACS_RST_TIMING;
		end else if (CE_I && acc_wr) begin
			if (hit_a) ctrl_a_reg <= wmerge(ctrl_a_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			if (hit_f) ctrl_f_reg <= wmerge(ctrl_f_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
			if (hit_t) timing_reg <= wmerge(timing_reg, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration fields
	logic enable;
	logic keep_analog_powered;
	logic auto_restart;
	logic [3:0] count_log;
	logic [7:0] sample_duration;
	logic [7:0] prescale_half;
	acs_mode_t conv_mode;
	logic accum_mode;
	logic [10:0] accumulate_count;

	assign enable = ctrl_a_reg[`ACS_A_ENABLE];
	assign keep_analog_powered = ctrl_a_reg[`ACS_A_KEEP];
	assign auto_restart = ctrl_f_reg[`ACS_F_RESTART];
	assign count_log = (ctrl_f_reg[`ACS_F_COUNT_MSB:`ACS_F_COUNT_LSB] > `ACS_MAX_COUNT_LOG) ?
		`ACS_MAX_COUNT_LOG : ctrl_f_reg[`ACS_F_COUNT_MSB:`ACS_F_COUNT_LSB];
	assign sample_duration = timing_reg[`ACS_T_SD_MSB:`ACS_T_SD_LSB];
	assign prescale_half = (timing_reg[`ACS_T_PRE_MSB:`ACS_T_PRE_LSB] == 8'h00) ? 8'h01 :
		timing_reg[`ACS_T_PRE_MSB:`ACS_T_PRE_LSB];
	assign conv_mode = acs_mode_t'(timing_reg[`ACS_T_MODE_MSB:`ACS_T_MODE_LSB]);
	assign accum_mode = conv_mode == ACS_MODE_SERIES || conv_mode == ACS_MODE_BURST;
	// Samples per accumulation, up to 1024
	assign accumulate_count = accum_mode ? (11'h001 << count_log) : 11'h001;

	////////////////////////////////////////////////////////////////////////
	// Analog data synchroniser
	logic [11:0] data_s1_reg;
	logic [11:0] data_s2_reg;
	logic [`ACS_ACC_W-1:0] sample_value;

	always_ff @(posedge CLK_I or negedge rstn) begin
		if (!rstn) begin
			data_s1_reg <= 12'h000;
			data_s2_reg <= 12'h000;
		end else if (CE_I) begin
			data_s1_reg <= ADC_DATA_I;
			data_s2_reg <= data_s1_reg;
		end
	end
	assign sample_value = (conv_mode == ACS_MODE_SINGLE8) ?
		{14'h0000, data_s2_reg[11:4]} : {10'h000, data_s2_reg};

	////////////////////////////////////////////////////////////////////////
	// Sequencer timing
	acs_state_t state_reg;
	acs_state_t state_next;
	logic [7:0] div_reg;
	logic [15:0] cnt_reg;
	logic [15:0] phase_len;
	logic half_tick;
	logic timed;
	logic phase_done;
	logic [10:0] smp_reg;
	logic last_sample;
	logic sample_final;
	logic publish;
	logic to_idle;
	logic restart;
	logic start_pend_reg;
	logic take_start;
	logic cmd_start;
	logic analog_on_reg;
	logic ready_reg;
	logic [`ACS_ACC_W-1:0] acc_reg;
	logic [`ACS_ACC_W-1:0] result_reg;

	assign half_tick = div_reg == prescale_half - 8'h01;
	assign timed = state_reg != ACS_ST_IDLE && state_reg != ACS_ST_INIT &&
		state_reg != ACS_ST_LATCH && state_reg != ACS_ST_ACCUM;
	// Phase lengths in converter half cycles
	assign phase_len = (state_reg == ACS_ST_SAMPLE) ? {7'h00, sample_duration, 1'b1} :
		(state_reg == ACS_ST_CONVERT) ?
		((conv_mode == ACS_MODE_SINGLE8) ? `ACS_CONV8_CYC << 1 : `ACS_CONV12_CYC << 1) :
		16'h0001;
	assign phase_done = (state_reg == ACS_ST_INIT) ? (cnt_reg + 16'h0001 == 16'(INIT_CYCLES)) :
		(timed && half_tick && cnt_reg + 16'h0001 == phase_len);
	assign last_sample = smp_reg + 11'h001 >= accumulate_count;
	// Sample just taken completed the accumulation
	assign sample_final = smp_reg >= accumulate_count;
	// Final result goes out after the latch cycle, plus one for accumulation
	assign publish = (state_reg == ACS_ST_ACCUM) ||
		(state_reg == ACS_ST_LATCH && !accum_mode);
	assign restart = publish && auto_restart && enable;
	assign to_idle = (state_reg == ACS_ST_LATCH && accum_mode && !sample_final) ||
		(publish && !restart);
	assign cmd_start = acc_wr && hit_c && AVS_BYTEENABLE_I[0] && AVS_WRITEDATA_I[`ACS_C_START];
	assign take_start = state_reg == ACS_ST_IDLE && start_pend_reg && enable;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ACS_ST_IDLE: begin
				if (take_start) begin
					// Powered analog needs no initialisation
					state_next = analog_on_reg ? ACS_ST_START : ACS_ST_INIT;
				end
			end
			ACS_ST_INIT: begin
				if (phase_done) state_next = ACS_ST_START;
			end
			ACS_ST_START: begin
				if (phase_done) state_next = ACS_ST_SAMPLE;
			end
			ACS_ST_SAMPLE: begin
				if (phase_done) state_next = ACS_ST_CONVERT;
			end
			ACS_ST_CONVERT: begin
				if (phase_done) state_next = ACS_ST_GAP;
			end
			ACS_ST_GAP: begin
				if (phase_done) begin
					// Burst goes straight to the next sample
					state_next = (conv_mode == ACS_MODE_BURST && !last_sample) ?
						ACS_ST_SAMPLE : ACS_ST_LATCH;
				end
			end
			ACS_ST_LATCH: begin
				if (accum_mode && sample_final) state_next = ACS_ST_ACCUM;
				else if (restart) state_next = ACS_ST_START;
				else state_next = ACS_ST_IDLE;
			end
			ACS_ST_ACCUM: begin
				state_next = restart ? ACS_ST_START : ACS_ST_IDLE;
			end
			default: begin
				state_next = ACS_ST_IDLE;
			end
		endcase
		if (!enable) state_next = ACS_ST_IDLE;
	end

	always_ff @(posedge CLK_I or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ACS_ST_IDLE;
			div_reg <= 8'h00;
			cnt_reg <= 16'h0000;
		end else if (CE_I) begin
			state_reg <= state_next;
			if (state_next != state_reg || phase_done) begin
				div_reg <= 8'h00;
				cnt_reg <= 16'h0000;
			end else if (state_reg == ACS_ST_INIT) begin
				cnt_reg <= cnt_reg + 16'h0001;
			end else if (half_tick) begin
				div_reg <= 8'h00;
				cnt_reg <= cnt_reg + 16'h0001;
			end else begin
				div_reg <= div_reg + 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Start request, analog power, accumulation, result
	always_ff @(posedge CLK_I or negedge rstn) begin
		if (!rstn) begin
			start_pend_reg <= 1'b0;
			analog_on_reg <= 1'b0;
		end else if (CE_I) begin
			start_pend_reg <= cmd_start | (start_pend_reg & ~take_start);
			if (!enable) analog_on_reg <= 1'b0;
			else if (state_reg == ACS_ST_INIT && phase_done) analog_on_reg <= 1'b1;
			else if (to_idle) analog_on_reg <= keep_analog_powered;
		end
	end

	always_ff @(posedge CLK_I or negedge rstn) begin
		if (!rstn) begin
			smp_reg <= 11'h000;
			acc_reg <= '0;
			result_reg <= '0;
			ready_reg <= 1'b0;
		end else if (CE_I) begin
			if (!enable) begin
				smp_reg <= 11'h000;
			end else if (state_reg == ACS_ST_GAP && phase_done) begin
				// Full-width sum of up to 1024 samples
				acc_reg <= (smp_reg == 11'h000) ? sample_value : acc_reg + sample_value;
				smp_reg <= smp_reg + 11'h001;
			end else if (publish) begin
				smp_reg <= 11'h000;
			end
			if (publish) result_reg <= acc_reg;
			ready_reg <= publish | (ready_reg & ~(acc_rd & hit_r));
		end
	end

	assign status_word = {29'h0000_0000, analog_on_reg, ready_reg, state_reg != ACS_ST_IDLE};
	assign result_word = {10'h000, result_reg};

	////////////////////////////////////////////////////////////////////////
	// Analog stage controls
	assign ANALOG_ON_O = analog_on_reg;
	assign SAMPLE_O = state_reg == ACS_ST_SAMPLE;
	assign CONVERT_O = state_reg == ACS_ST_CONVERT;
	assign RES8_O = conv_mode == ACS_MODE_SINGLE8;

endmodule // acs_sequencer

// File: testbench/acs_sequencer_assertions.sv
/*
 * Port checks of the conversion sequencer.
 * Assumes a bind from the bench top, CE_I held high, prescale set before a run.
 */
`timescale 1ns/100ps
module acs_sequencer_assertions (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RSTN_I,
	// Register bus
	input wire logic [4:0] AVS_ADDRESS_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_WRITEDATA_I,
	input wire logic [3:0] AVS_BYTEENABLE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	// Analog stage
	input wire logic ANALOG_ON_O,
	input wire logic SAMPLE_O,
	input wire logic CONVERT_O,
	input wire logic RES8_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	logic [17:0] tim_reg;
	logic keep_reg;
	logic [31:0] cv_reg;
	logic [31:0] sa_reg;
	wire logic wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O;
	wire logic rd_ok = AVS_READ_I && !AVS_WAITREQUEST_O;
	wire logic [31:0] h = (tim_reg[15:8] == 8'h00) ? 32'h1 : {24'h0, tim_reg[15:8]};
	////////////////////////////////////////////////////////////////////////////
	// Shadow of timing word and keep-powered state
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			tim_reg <= 18'h00114;
			keep_reg <= 1'b0;
		end else if (wr_ok && AVS_ADDRESS_I == 5'h08) begin
			if (AVS_BYTEENABLE_I[0]) tim_reg[7:0] <= AVS_WRITEDATA_I[7:0];
			if (AVS_BYTEENABLE_I[1]) tim_reg[15:8] <= AVS_WRITEDATA_I[15:8];
			if (AVS_BYTEENABLE_I[2]) tim_reg[17:16] <= AVS_WRITEDATA_I[17:16];
		end else if (wr_ok && AVS_ADDRESS_I == 5'h00 && AVS_BYTEENABLE_I[0]) begin
			keep_reg <= &AVS_WRITEDATA_I[1:0];
		end
	end
	// Phase lengths in main cycles
	always_ff @(posedge CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			cv_reg <= 32'h0;
			sa_reg <= 32'h0;
		end else begin
			cv_reg <= CONVERT_O ? cv_reg + 32'h1 : 32'h0;
			sa_reg <= SAMPLE_O ? sa_reg + 32'h1 : 32'h0;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	a_conv_length: assert property ($fell(CONVERT_O) |->
		cv_reg == (RES8_O ? 32'h12 : 32'h1A) * h)
		else $error("conversion phase length wrong");
	a_sample_length: assert property ($fell(SAMPLE_O) |->
		sa_reg == ({24'h0, tim_reg[7:0]} * 32'h2 + 32'h1) * h)
		else $error("sampling phase length wrong");
	a_res8_mode: assert property (RES8_O == (tim_reg[17:16] == 2'h1))
		else $error("8-bit flag disagrees with mode");
	a_keep_powered: assert property ($fell(CONVERT_O) && keep_reg |-> ANALOG_ON_O [*4])
		else $error("analog powered down while keep set");
	a_powered_phase: assert property (SAMPLE_O || CONVERT_O |-> ANALOG_ON_O)
		else $error("sampling or converting unpowered");
	a_convert_follows: assert property ($fell(SAMPLE_O) |-> CONVERT_O)
		else $error("conversion did not follow sampling");
	a_wait_one: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("bus wait longer than one cycle");
	a_unmapped_zero: assert property (rd_ok && AVS_ADDRESS_I > 5'h14 |-> AVS_READDATA_O == 32'h0)
		else $error("unmapped read not zero");
	a_timing_read: assert property (rd_ok && AVS_ADDRESS_I == 5'h08 |-> AVS_READDATA_O[17:0] == tim_reg)
		else $error("timing readback wrong");
endmodule // acs_sequencer_assertions

// File: testbench/acs_analog_model.sv
/*
 * Analog sample-and-convert stage model.
 * Assumes the sequencer takes its sample only while the stage is powered.
 */
`timescale 1ns/100ps
module acs_analog_model #(
	parameter logic [11:0] VALUE = 12'hA5C
) (
	// Power state
	input wire logic analog_on_i,
	// Result
	output logic [11:0] data_o
);
	// Unpowered stage shows the inverted code
	// Direct sampling, no gain stage in front
	assign data_o = analog_on_i ? VALUE : ~VALUE;
endmodule // acs_analog_model

// File: testbench/acs_sequencer_tb.sv
/*
 * Register-level bench of the conversion sequencer.
 * Assumes a 20 MHz clock, prescale 1 and a constant analog code.
 */
`timescale 1ns/100ps
module acs_sequencer_tb;
	localparam logic [11:0] VAL = 12'hA5C;
	logic CLK_I, RSTN_I, CE_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O;
	logic ANALOG_ON_O, SAMPLE_O, CONVERT_O, RES8_O;
	logic [4:0] AVS_ADDRESS_I;
	logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O;
	logic [3:0] AVS_BYTEENABLE_I;
	logic [11:0] ADC_DATA_I;
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	acs_sequencer #(.INIT_CYCLES(4)) acs_sequencer_inst (
		.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I),
		.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
		.AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I),
		.AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
		.ADC_DATA_I(ADC_DATA_I), .ANALOG_ON_O(ANALOG_ON_O), .SAMPLE_O(SAMPLE_O),
		.CONVERT_O(CONVERT_O), .RES8_O(RES8_O));
	acs_analog_model #(.VALUE(VAL)) acs_analog_model_inst (
		.analog_on_i(ANALOG_ON_O), .data_o(ADC_DATA_I));
	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest seen low at an edge
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge CLK_I);
		AVS_ADDRESS_I <= a;
		AVS_WRITEDATA_I <= d;
		AVS_WRITE_I <= wr;
		AVS_READ_I <= !wr;
		do @(posedge CLK_I); while (AVS_WAITREQUEST_O !== 1'b0);
		q = AVS_READDATA_O;
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic wait_st(input int b, input logic v);
		logic [31:0] q;
		do bus(1'b0, 5'h10, 32'h0, q); while (q[b] !== v);
	endtask
	// Main cycles from one sampling start to the next
	task automatic per(output logic [31:0] n);
		logic p;
		int k;
		k = 0;
		n = 32'h0;
		p = 1'b1;
		while (k < 2) begin
			@(negedge CLK_I);
			if (SAMPLE_O === 1'b1 && p === 1'b0) k++;
			p = SAMPLE_O;
			if (k == 1) n++;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		CLK_I = 1'b0;
		forever #25 CLK_I = ~CLK_I;
	end
	always @(posedge CLK_I) begin
		cyc++;
		if (cyc == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end
	initial begin
		logic [31:0] n;
		RSTN_I = 1'b0;
		CE_I = 1'b1;
		AVS_READ_I = 1'b0;
		AVS_WRITE_I = 1'b0;
		AVS_ADDRESS_I = 5'h00;
		AVS_WRITEDATA_I = 32'h0;
		AVS_BYTEENABLE_I = 4'hF;
		repeat (5) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		repeat (3) @(posedge CLK_I);
		rdchk(5'h00, 32'h0);
		rdchk(5'h04, 32'h0);
		rdchk(5'h08, 32'h00000114);
		wr(5'h18, 32'hFFFFFFFF);
		rdchk(5'h18, 32'h0);
		// Single 12-bit, auto restart, kept powered
		wr(5'h08, 32'h00000104);
		wr(5'h04, 32'h00000010);
		wr(5'h00, 32'h00000003);
		wr(5'h0C, 32'h00000001);
		per(n);
		chk(n, 32'h00000026);
		rdchk(5'h14, {20'h0, VAL});
		wr(5'h04, 32'h0);
		wait_st(0, 1'b0);
		// Single 8-bit
		wr(5'h08, 32'h00010104);
		wr(5'h04, 32'h00000010);
		wr(5'h0C, 32'h00000001);
		per(n);
		chk(n, 32'h0000001E);
		wr(5'h04, 32'h0);
		wait_st(0, 1'b0);
		rdchk(5'h14, {24'h0, VAL[11:4]});
		// Burst of four, then of 1024
		wr(5'h08, 32'h00030102);
		wr(5'h04, 32'h00000002);
		wr(5'h0C, 32'h00000001);
		per(n);
		chk(n, 32'h00000020);
		wait_st(1, 1'b1);
		rdchk(5'h14, {20'h0, VAL} << 2);
		wr(5'h04, 32'h0000000A);
		wr(5'h0C, 32'h00000001);
		wait_st(1, 1'b1);
		rdchk(5'h14, {20'h0, VAL} << 10);
		// Series of two without keep
		wr(5'h00, 32'h00000001);
		wr(5'h08, 32'h00020104);
		wr(5'h04, 32'h00000001);
		wr(5'h0C, 32'h00000001);
		@(negedge CONVERT_O);
		repeat (4) @(negedge CLK_I);
		chk({31'h0, ANALOG_ON_O}, 32'h0);
		wr(5'h0C, 32'h00000001);
		wait_st(1, 1'b1);
		rdchk(5'h14, {20'h0, VAL} << 1);
		stop_test();
	end
endmodule // acs_sequencer_tb

bind acs_sequencer acs_sequencer_assertions acs_sequencer_assertions_inst (
	.CLK_I(CLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
	.AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
	.AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .ANALOG_ON_O(ANALOG_ON_O),
	.SAMPLE_O(SAMPLE_O), .CONVERT_O(CONVERT_O), .RES8_O(RES8_O));
